/* File: src/hdlc_status_interrupt_flags.sv */
// Operation
// - code detector change of state sets flag
// - packet opening byte sets start flag
// - rx half-full while fifo above half
// - rx not-empty while fifo holds byte
// - tx half-empty once fifo below half
// - tx not-full while fifo has room
// - event flags latch, clear on status read
// - mask bit per event, one enables
// - enabled event drives interrupt low
// - interrupt releases after read, none pending
`timescale 1ns/1ps
module hdlc_status_interrupt_flags (
  input wire logic sys_clk,
  input wire logic rst,
  // host register port, synchronous strobes
  input wire logic [hdlc_flags_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [hdlc_flags_pkg::DATA_W-1:0] reg_wdata,
  output logic [hdlc_flags_pkg::DATA_W-1:0] reg_rdata,
  // event sources from the hdlc and code engines
  input wire logic code_detected,
  input wire logic rx_open_byte,
  input wire logic rx_close_byte,
  input wire logic tx_msg_done,
  input wire logic [hdlc_flags_pkg::LEVEL_W-1:0] rx_fifo_level,
  input wire logic [hdlc_flags_pkg::LEVEL_W-1:0] tx_fifo_level,
  // shared interrupt, active low
  output logic int_n
);

  // address compare, used for both reads and writes
  function automatic logic addr_is(input logic [hdlc_flags_pkg::ADDR_W-1:0] a,
                                   input logic [hdlc_flags_pkg::ADDR_W-1:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  logic [hdlc_flags_pkg::DATA_W-1:0] latch_r; // sticky event bits
  logic [hdlc_flags_pkg::DATA_W-1:0] latch_nxt; // sticky bits after this edge
  logic [hdlc_flags_pkg::DATA_W-1:0] mask_r; // interrupt enables
  logic [hdlc_flags_pkg::DATA_W-1:0] mask_nxt; // enables after a possible write
  logic [hdlc_flags_pkg::DATA_W-1:0] rdata_r; // read data holding register
  logic [hdlc_flags_pkg::DATA_W-1:0] rdata_nxt; // read data after this edge
  logic code_prev_r; // last seen code detector level
  logic int_n_r; // registered interrupt pin, active low
  logic int_n_nxt; // pin value after this edge

  // register decodes; a read and a write in the same cycle share reg_addr and both act
  wire rd_status = reg_rd && addr_is(reg_addr, hdlc_flags_pkg::ADDR_STATUS);
  wire rd_mask = reg_rd && addr_is(reg_addr, hdlc_flags_pkg::ADDR_MASK);
  wire wr_mask = reg_wr && addr_is(reg_addr, hdlc_flags_pkg::ADDR_MASK);

  // a level change in either direction counts, so loss and gain both report
  wire code_change = code_detected ^ code_prev_r;

  // one-cycle event pulses in their status positions
  logic [hdlc_flags_pkg::DATA_W-1:0] ev_set;
  always_comb begin
    ev_set = hdlc_flags_pkg::STATUS_RESET;
    ev_set[hdlc_flags_pkg::BIT_CODE_CHG] = code_change;
    ev_set[hdlc_flags_pkg::BIT_RX_END] = rx_close_byte;
    ev_set[hdlc_flags_pkg::BIT_RX_START] = rx_open_byte;
    ev_set[hdlc_flags_pkg::BIT_TX_END] = tx_msg_done;
  end

  // live bits follow fifo state and are never latched
  logic [hdlc_flags_pkg::DATA_W-1:0] live;
  always_comb begin
    live = hdlc_flags_pkg::STATUS_RESET;
    live[hdlc_flags_pkg::BIT_RX_HALF] = rx_fifo_level > hdlc_flags_pkg::FIFO_HALF;
    live[hdlc_flags_pkg::BIT_RX_NE] = rx_fifo_level != hdlc_flags_pkg::FIFO_NONE;
    live[hdlc_flags_pkg::BIT_TX_HALF] = tx_fifo_level < hdlc_flags_pkg::FIFO_HALF;
    live[hdlc_flags_pkg::BIT_TX_NF] = tx_fifo_level < hdlc_flags_pkg::FIFO_DEPTH;
  end

  // value software sees in the status register this cycle
  wire [hdlc_flags_pkg::DATA_W-1:0] status_cur = (latch_r & hdlc_flags_pkg::LATCHED_BITS) | live;

  // read clears the sticky bits, but an event in the same cycle wins
  wire [hdlc_flags_pkg::DATA_W-1:0] clr_bits =
    rd_status ? hdlc_flags_pkg::LATCHED_BITS : hdlc_flags_pkg::STATUS_RESET;
  assign latch_nxt = ((latch_r & ~clr_bits) | ev_set) & hdlc_flags_pkg::LATCHED_BITS;

  // only the mask is writable; a write to the status address has no effect
  assign mask_nxt = wr_mask ? reg_wdata : mask_r;

  // unmapped addresses read as zero; idle cycles hold the last read data
  assign rdata_nxt = rd_status ? status_cur :
                     rd_mask ? mask_r :
                     reg_rd ? hdlc_flags_pkg::READ_IDLE : rdata_r;

  // interrupt is computed from next state so it tracks the register edge
  wire [hdlc_flags_pkg::DATA_W-1:0] pend_nxt =
    (((latch_nxt & hdlc_flags_pkg::LATCHED_BITS) | live) & mask_nxt);
  assign int_n_nxt = ~(|pend_nxt);

  // sticky flags and mask
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_r <= hdlc_flags_pkg::STATUS_RESET;
      mask_r <= hdlc_flags_pkg::MASK_RESET;
    end else begin
      latch_r <= latch_nxt;
      mask_r <= mask_nxt;
    end
  end

  // read data, code history and interrupt pin
  // limitation: a live bit that drops before the read also drops the pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= hdlc_flags_pkg::READ_IDLE;
      code_prev_r <= 1'b0;
      int_n_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      code_prev_r <= code_detected;
      int_n_r <= int_n_nxt;
    end
  end

  // both outputs come straight from flip-flops
  assign reg_rdata = rdata_r;
  assign int_n = int_n_r;

  // named steps used by the checks below
  // a status read in a cycle with no event pulse, so every sticky bit drops
  sequence status_read_quiet;
    rd_status && (ev_set == hdlc_flags_pkg::STATUS_RESET);
  endsequence
  // no enabled live level is left to hold the pin low after the read
  sequence no_live_pending;
    ((live & mask_nxt) == hdlc_flags_pkg::STATUS_RESET);
  endsequence
  // a status read, taken one cycle before its data stands on the port
  sequence status_read_taken;
    rd_status;
  endsequence

  // either direction of the code detector level must be reported
  code_change_a: assert property (@(posedge sys_clk) disable iff (rst)
    (code_detected != code_prev_r) |=> status_cur[hdlc_flags_pkg::BIT_CODE_CHG])
    else $error("code change did not set flag");

  // an opening byte must show as a start flag on the next cycle
  pkt_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_open_byte |=> status_cur[hdlc_flags_pkg::BIT_RX_START])
    else $error("opening byte did not set start flag");

  // live bits are judged through the read port, one cycle after the read
  rx_half_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_taken |=> reg_rdata[hdlc_flags_pkg::BIT_RX_HALF]
      == ($past(rx_fifo_level) > hdlc_flags_pkg::FIFO_HALF))
    else $error("rx half-full flag wrong");

  // any byte in the receive fifo must read as not-empty
  rx_nempty_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_taken |=> reg_rdata[hdlc_flags_pkg::BIT_RX_NE]
      == ($past(rx_fifo_level) != hdlc_flags_pkg::FIFO_NONE))
    else $error("rx not-empty flag wrong");

  // strictly below the half-way point reads as half-empty
  tx_half_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_taken |=> reg_rdata[hdlc_flags_pkg::BIT_TX_HALF]
      == ($past(tx_fifo_level) < hdlc_flags_pkg::FIFO_HALF))
    else $error("tx half-empty flag wrong");

  // any free room in the transmit fifo reads as not-full
  tx_nfull_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_taken |=> reg_rdata[hdlc_flags_pkg::BIT_TX_NF]
      == ($past(tx_fifo_level) < hdlc_flags_pkg::FIFO_DEPTH))
    else $error("tx not-full flag wrong");

  // a quiet status read returns the register and clears the sticky bits
  read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_quiet |=> ((latch_r & hdlc_flags_pkg::LATCHED_BITS) == hdlc_flags_pkg::STATUS_RESET)
      && (reg_rdata == $past(status_cur)))
    else $error("status read did not return and clear flags");

  // message end stays up until software reads it
  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (status_cur[hdlc_flags_pkg::BIT_TX_END] && !rd_status)
      |=> status_cur[hdlc_flags_pkg::BIT_TX_END])
    else $error("latched flag dropped without read");

  // no sticky bit may fall in a cycle that holds no status read
  sticky_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_status |=> ((latch_r & $past(latch_r)) == $past(latch_r)))
    else $error("sticky flag dropped without read");

  // a mask write lands at the next edge
  mask_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_mask |=> (mask_r == $past(reg_wdata)))
    else $error("mask write not stored");

  // a mask read returns the mask held at the read edge
  mask_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_mask |=> (reg_rdata == $past(mask_r)))
    else $error("mask read returned wrong value");

  // the pin is registered, so a live level reaches it one cycle late
  int_assert_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((((latch_r & hdlc_flags_pkg::LATCHED_BITS) | $past(live)) & mask_r)
      != hdlc_flags_pkg::STATUS_RESET) |-> !int_n)
    else $error("enabled event did not pull interrupt low");

  // with nothing enabled and pending the pin must stand high
  int_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((((latch_r & hdlc_flags_pkg::LATCHED_BITS) | $past(live)) & mask_r)
      == hdlc_flags_pkg::STATUS_RESET) |-> int_n)
    else $error("interrupt low with nothing pending");

  // reading the cause releases the pin when nothing else is pending
  int_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_read_quiet ##0 no_live_pending |=> int_n)
    else $error("interrupt not released after read");

  // a closing byte, good packet or bad, sets the end flag
  pkt_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_close_byte |=> status_cur[hdlc_flags_pkg::BIT_RX_END])
    else $error("closing byte did not set end flag");

  // a finished transmit message sets its end flag
  tx_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_msg_done |=> status_cur[hdlc_flags_pkg::BIT_TX_END])
    else $error("message end did not set flag");

endmodule : hdlc_status_interrupt_flags

/* File: src/hdlc_flags_pkg.sv */
package hdlc_flags_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LEVEL_W = 7;
  // register addresses on the parallel control port
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h02;
  // status and mask bit positions, shared by both registers
  localparam int BIT_CODE_CHG = 7;
  localparam int BIT_RX_END = 6;
  localparam int BIT_RX_START = 5;
  localparam int BIT_RX_HALF = 4;
  localparam int BIT_RX_NE = 3;
  localparam int BIT_TX_HALF = 2;
  localparam int BIT_TX_NF = 1;
  localparam int BIT_TX_END = 0;
  // bits that latch and clear on a status read
  localparam logic [DATA_W-1:0] LATCHED_BITS = 8'hE1;
  // reset values
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
  // fifo capacity and half-way point, in bytes
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 7'h40;
  localparam logic [LEVEL_W-1:0] FIFO_HALF = 7'h20;
  localparam logic [LEVEL_W-1:0] FIFO_NONE = 7'h00;
endpackage : hdlc_flags_pkg

/* File: tb/test_hdlc_status_interrupt_flags.sv */
`timescale 1ns/1ps
module test_hdlc_status_interrupt_flags;
  logic sys_clk = 1'b0; // 25 mhz bench clock
  logic rst = 1'b1; // held high at start
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_rd = 1'b0, reg_wr = 1'b0, code_detected = 1'b0, rx_open_byte = 1'b0;
  logic rx_close_byte = 1'b0, tx_msg_done = 1'b0, int_n;
  logic [6:0] rx_fifo_level = 7'h00, tx_fifo_level = 7'h00; // fifo byte counts
  int err_total = 0, check_count = 0;
  int rl[5] = '{0, 1, 32, 33, 64}; // rx levels around the half-way boundary
  int tl[5] = '{64, 63, 32, 31, 0}; // tx levels, full down to empty
  hdlc_status_interrupt_flags dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .code_detected(code_detected), .rx_open_byte(rx_open_byte),
    .rx_close_byte(rx_close_byte), .tx_msg_done(tx_msg_done),
    .rx_fifo_level(rx_fifo_level), .tx_fifo_level(tx_fifo_level), .int_n(int_n));
  // free-running clock, 40 ns period
  initial forever #20 sys_clk = ~sys_clk;
  // live level bits as the status register should show them
  function automatic logic [7:0] live(input int r, input int t);
    return {3'b000, r > 32, r != 0, t < 32, t < 64, 1'b0};
  endfunction : live
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // read: data is sampled one edge after the answer so it has settled
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk) reg_rd <= 1'b0;
    @(posedge sys_clk) #1 v = reg_rdata;
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  // one-cycle event pulses; code level is left where it was set
  task ev(input logic o, input logic c, input logic m, input logic k);
    @(posedge sys_clk) rx_open_byte <= o;
    rx_close_byte <= c;
    tx_msg_done <= m;
    code_detected <= k;
    @(posedge sys_clk) rx_open_byte <= 1'b0;
    rx_close_byte <= 1'b0;
    tx_msg_done <= 1'b0;
  endtask : ev
  task t_latch;
    ev(1'b1, 1'b1, 1'b1, 1'b1);
    rd(8'h01, d);
    chk("status", d, 8'hE7);
    rd(8'h01, d);
    chk("status", d, 8'h06);
    ev(1'b0, 1'b0, 1'b0, 1'b0);
    rd(8'h01, d);
    chk("status", d, 8'h86);
  endtask : t_latch
  task t_levels;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) rx_fifo_level <= 7'(rl[i]);
      tx_fifo_level <= 7'(tl[i]);
      rd(8'h01, d);
      chk("status", d, live(rl[i], tl[i]));
    end
  endtask : t_levels
  // status is read-only; unmapped reads return zero
  task t_mask;
    wr(8'h02, 8'hA5);
    wr(8'h01, 8'hFF);
    rd(8'h01, d);
    chk("status", d, 8'h1E);
    rd(8'h02, d);
    chk("mask", d, 8'hA5);
    rd(8'h03, d);
    chk("unmapped", d, 8'h00);
  endtask : t_mask
  task t_irq;
    @(posedge sys_clk) rx_fifo_level <= 7'h00;
    tx_fifo_level <= 7'h40;
    wr(8'h02, 8'h20);
    @(posedge sys_clk) #1 chk("int_n", {7'h00, int_n}, 8'h01);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk) #1 chk("int_n", {7'h00, int_n}, 8'h00);
    // a start pulse landing on the read edge must survive the clear
    @(posedge sys_clk) reg_rd <= 1'b1;
    reg_addr <= 8'h01;
    rx_open_byte <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    rx_open_byte <= 1'b0;
    @(posedge sys_clk) #1 chk("int_n", {7'h00, int_n}, 8'h00);
    rd(8'h01, d);
    chk("status", d, 8'h20);
    @(posedge sys_clk) #1 chk("int_n", {7'h00, int_n}, 8'h01);
    // live bit raises and drops the line with no read
    wr(8'h02, 8'h02);
    @(posedge sys_clk) tx_fifo_level <= 7'h0A;
    repeat (2) @(posedge sys_clk);
    #1 chk("int_n", {7'h00, int_n}, 8'h00);
    @(posedge sys_clk) tx_fifo_level <= 7'h40;
    repeat (2) @(posedge sys_clk);
    #1 chk("int_n", {7'h00, int_n}, 8'h01);
  endtask : t_irq
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // watchdog: a hang counts as a mismatch
  initial begin
    #2000000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("int_n", {7'h00, int_n}, 8'h01);
    rd(8'h02, d);
    chk("mask", d, 8'h00);
    rd(8'h01, d);
    chk("status", d, 8'h06);
    t_latch();
    t_levels();
    t_mask();
    t_irq();
    test_done();
  end
endmodule : test_hdlc_status_interrupt_flags
